// File: rtl/instr_timing_regs.vh
// constants for the instruction timing and interlock controller
// assumes inclusion by instruction_timing_interlock.v and by the testbench
`ifndef INSTR_TIMING_REGS_VH
`define INSTR_TIMING_REGS_VH

// instruction classes presented on class_i
`define CLS_DATA_OP      4'h0
`define CLS_SINGLE_LOAD  4'h1
`define CLS_SINGLE_STORE 4'h2
`define CLS_BLOCK_LOAD   4'h3
`define CLS_BLOCK_STORE  4'h4
`define CLS_SWAP         4'h5
`define CLS_CP_DATA      4'h6
`define CLS_CP_MEM       4'h7
`define CLS_CP_WRITE     4'h8
`define CLS_CP_READ      4'h9
`define CLS_STATUS_WRITE 4'ha
`define CLS_MULTIPLY     4'hb

// bus cycle types
`define BUS_I 2'h0
`define BUS_N 2'h1
`define BUS_S 2'h2
`define BUS_C 2'h3

// cycle counts
`define CYC_ONE          7'h01
`define CYC_TWO          7'h02
`define CYC_THREE        7'h03
`define CYC_FOUR         7'h04
`define CYC_FIVE         7'h05
`define MUL_BASE_SHORT   7'h02
`define MUL_BASE_LONG    7'h03

`endif

// File: rtl/instruction_timing_interlock.v
// cycle timing and interlock sequencer for one issued instruction at a time
// assumes the decoder presents class and flags with issue_i while ready_o is high,
// and that the register file returns mul_operand_i for mul_reg_sel_o in the cycle after issue
//
// Contract
// - data op: 1 cycle, 2 with register shift
// - pc-writing data op: 3, or 4 cycles
// - word load 1 cycle, 2 if used next
// - narrow load used next takes 3 cycles
// - load into pc takes 5 cycles
// - block load: 2 for one, else n
// - block load with pc: n+4 cycles
// - block store 2 or n; N then S
// - word swap 2/3, byte swap 3
// - coprocessor ops stretched by b busy cycles
// - coprocessor read used next: b+2 cycles
// - status write: flags 1, otherwise 3
// - multiplies 2+m, long multiplies 3+m cycles
// - signed m from sign-extension width of operand
// - unsigned long m from zero-extension width only
// - operand register from bits 11:8 or 2:0
// - interlock halts instruction fetches, not the S fetch of a b=0 coprocessor read or last-register pc block load
// - block load transfers ascending register order
// - earlier-register user waits for final fetch
// - last-register user adds one interlock cycle
// - external accesses stretch by system-decided cycles
`timescale 1ns/1ns
`include "instr_timing_regs.vh"

module instruction_timing_interlock (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  input  wire        issue_i,
  input  wire [3:0]  class_i,
  input  wire        pc_dest_i,
  input  wire        reg_shift_i,
  input  wire        next_uses_i,
  input  wire        narrow_i,
  input  wire        flags_only_i,
  input  wire        long_mul_i,
  input  wire        unsigned_mul_i,
  input  wire        compressed_i,
  input  wire [31:0] instr_i,
  input  wire [15:0] reg_list_i,
  input  wire [4:0]  coproc_busy_i,
  input  wire [4:0]  coproc_words_i,
  input  wire        dep_last_i,
  input  wire [31:0] mul_operand_i,
  input  wire        ext_wait_i,
  output wire        ready_o,
  output wire        busy_o,
  output wire        done_o,
  output wire [6:0]  cycles_o,
  output wire [1:0]  dbus_type_o,
  output wire [1:0]  ibus_type_o,
  output wire        ifetch_stall_o,
  output wire        interlock_o,
  output wire        xfer_valid_o,
  output wire [3:0]  xfer_reg_o,
  output wire [3:0]  mul_reg_sel_o
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_MULQ = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;
  reg [2:0]  state_r,     state_nxt;
  reg [6:0]  cnt_r,       cnt_nxt;
  reg [6:0]  k_r,         k_nxt;
  reg [6:0]  tot_r,       tot_nxt;
  reg [3:0]  cls_r,       cls_nxt;
  reg [4:0]  n_r,         n_nxt;
  reg [4:0]  b_r,         b_nxt;
  reg [15:0] mask_r,      mask_nxt;
  reg        pc_r,        pc_nxt,   use_r,     use_nxt,  dep_r,   dep_nxt;
  reg        lng_r,       lng_nxt,  uns_r,     uns_nxt;
  reg [3:0]  sel_r,       sel_nxt;
  reg        go,          done_nxt, ilock_nxt, xfer_nxt;
  reg [6:0]  c_issue;
  reg [4:0]  n_issue;
  reg [1:0]  dbus_nxt,    ibus_nxt;
  reg [3:0]  xreg_nxt;
  reg [15:0] mask_src;
  reg        ready_r,     busy_r,   done_r,    stall_r,  ilock_r, xfer_r;
  reg [1:0]  dbus_r,      ibus_r;
  reg [3:0]  xreg_r;

  function [4:0] popcount;
    input [15:0] v;
    integer i;
    begin
      popcount = 5'h00;
      for (i = 0; i < 16; i = i + 1)
        popcount = popcount + {4'h0, v[i]};
    end
  endfunction
  // scans downward so the lowest set bit is the one kept
  function [3:0] lowest;
    input [15:0] v;
    integer i;
    begin
      lowest = 4'h0;
      for (i = 15; i >= 0; i = i - 1)
        if (v[i]) lowest = i[3:0];
    end
  endfunction
  function [6:0] mul_m;
    input [31:0] op;
    input        uns;
    begin
      if (uns) begin
        if (op[31:8] == 24'h000000) mul_m = 7'h01;
        else if (op[31:16] == 16'h0000) mul_m = 7'h02;
        else if (op[31:24] == 8'h00) mul_m = 7'h03;
        else mul_m = 7'h04;
      end else begin
        if (op[31:8] == 24'h000000 || op[31:8] == 24'hffffff) mul_m = 7'h01;
        else if (op[31:16] == 16'h0000 || op[31:16] == 16'hffff) mul_m = 7'h02;
        else if (op[31:24] == 8'h00 || op[31:24] == 8'hff) mul_m = 7'h03;
        else mul_m = 7'h04;
      end
    end
  endfunction
  // total cycles known at issue; multiply gets its count once the operand is read
  always @* begin
    n_issue = popcount(reg_list_i);
    c_issue = `CYC_ONE;
    case (class_i)
      `CLS_DATA_OP: begin
        if (pc_dest_i) c_issue = reg_shift_i ? `CYC_FOUR : `CYC_THREE;
        else c_issue = reg_shift_i ? `CYC_TWO : `CYC_ONE;
      end
      `CLS_SINGLE_LOAD: begin
        if (pc_dest_i) c_issue = `CYC_FIVE;
        else if (next_uses_i) c_issue = narrow_i ? `CYC_THREE : `CYC_TWO;
        else c_issue = `CYC_ONE;
      end
      `CLS_SINGLE_STORE: c_issue = `CYC_ONE;
      `CLS_BLOCK_LOAD: begin
        if (pc_dest_i) c_issue = {2'b00, n_issue} + 7'h04;
        else if (n_issue == 5'h01) c_issue = `CYC_TWO;
        else c_issue = {2'b00, n_issue};
        c_issue = c_issue + {6'h00, dep_last_i};
      end
      `CLS_BLOCK_STORE: c_issue = (n_issue == 5'h01) ? `CYC_TWO : {2'b00, n_issue};
      `CLS_SWAP: c_issue = (narrow_i || next_uses_i) ? `CYC_THREE : `CYC_TWO;
      `CLS_CP_DATA: c_issue = {2'b00, coproc_busy_i} + `CYC_ONE;
      `CLS_CP_MEM: c_issue = {2'b00, coproc_busy_i} + {2'b00, coproc_words_i};
      `CLS_CP_WRITE: c_issue = {2'b00, coproc_busy_i} + `CYC_ONE;
      `CLS_CP_READ: c_issue = {2'b00, coproc_busy_i} + (next_uses_i ? `CYC_TWO : `CYC_ONE);
      `CLS_STATUS_WRITE: c_issue = flags_only_i ? `CYC_ONE : `CYC_THREE;
      `CLS_MULTIPLY: c_issue = `CYC_TWO;
      default: c_issue = `CYC_ONE;
    endcase
  end

  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    k_nxt     = k_r;
    tot_nxt   = tot_r;
    cls_nxt   = cls_r;
    n_nxt     = n_r;
    b_nxt     = b_r;
    pc_nxt    = pc_r;
    use_nxt   = use_r;
    dep_nxt   = dep_r;
    lng_nxt   = lng_r;
    uns_nxt   = uns_r;
    sel_nxt   = sel_r;
    done_nxt  = 1'b0;
    go        = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (issue_i) begin
          go        = 1'b1;
          cls_nxt   = class_i;
          pc_nxt    = pc_dest_i;
          use_nxt   = next_uses_i;
          dep_nxt   = dep_last_i;
          lng_nxt   = long_mul_i;
          uns_nxt   = unsigned_mul_i & long_mul_i;
          b_nxt     = coproc_busy_i;
          n_nxt     = (class_i == `CLS_CP_MEM) ? coproc_words_i : n_issue;
          sel_nxt   = compressed_i ? {1'b0, instr_i[2:0]} : instr_i[11:8];
          cnt_nxt   = c_issue;
          tot_nxt   = c_issue;
          k_nxt     = 7'h00;
          state_nxt = (class_i == `CLS_MULTIPLY) ? ST_MULQ : ST_RUN;
        end
      end
      ST_MULQ: begin
        if (!ext_wait_i) begin
          go        = 1'b1;
          tot_nxt   = (lng_r ? `MUL_BASE_LONG : `MUL_BASE_SHORT) + mul_m(mul_operand_i, uns_r);
          cnt_nxt   = tot_nxt - 7'h01;
          k_nxt     = k_r + 7'h01;
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!ext_wait_i) begin
          go = 1'b1;
          if (cnt_r == 7'h01) begin
            done_nxt  = 1'b1;
            state_nxt = ST_IDLE;
          end else begin
            cnt_nxt = cnt_r - 7'h01;
            k_nxt   = k_r + 7'h01;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // bus activity of the cycle about to start
  always @* begin
    dbus_nxt  = `BUS_I;
    ibus_nxt  = `BUS_I;
    ilock_nxt = 1'b0;
    xfer_nxt  = 1'b0;
    xreg_nxt  = 4'h0;
    mask_src  = (state_r == ST_IDLE) ? reg_list_i : mask_r;
    mask_nxt  = mask_r;
    if (state_nxt != ST_IDLE) begin
      case (cls_nxt)
        `CLS_SINGLE_LOAD: begin
          dbus_nxt  = (k_nxt == 7'h00) ? `BUS_N : `BUS_I;
          ilock_nxt = use_nxt && !pc_nxt && (k_nxt != 7'h00);
        end
        `CLS_SINGLE_STORE: dbus_nxt = `BUS_N;
        `CLS_BLOCK_LOAD, `CLS_BLOCK_STORE: begin
          if (k_nxt < {2'b00, n_nxt}) begin
            xfer_nxt = 1'b1;
            xreg_nxt = lowest(mask_src);
            mask_nxt = mask_src & ~(16'h0001 << xreg_nxt);
            if (k_nxt != 7'h00) dbus_nxt = `BUS_S;
            else if (cls_nxt == `CLS_BLOCK_LOAD && n_nxt == 5'h01 && !pc_nxt) dbus_nxt = `BUS_S;
            else dbus_nxt = `BUS_N;
          end
          if (cls_nxt == `CLS_BLOCK_LOAD) begin
            // earlier-register consumer held until the final fetch begins
            ilock_nxt = (use_nxt && k_nxt != 7'h00 && k_nxt + 7'h01 < {2'b00, n_nxt})
                        || (dep_nxt && k_nxt == tot_nxt - 7'h01);
          end
        end
        `CLS_SWAP: begin
          dbus_nxt  = (k_nxt < 7'h02) ? `BUS_N : `BUS_I;
          ilock_nxt = use_nxt && (k_nxt == 7'h02);
        end
        `CLS_CP_MEM: begin
          if (k_nxt == {2'b00, b_nxt}) dbus_nxt = `BUS_N;
          else if (k_nxt > {2'b00, b_nxt}) dbus_nxt = `BUS_S;
        end
        `CLS_CP_WRITE, `CLS_CP_READ: begin
          dbus_nxt  = (k_nxt == tot_nxt - 7'h01) ? `BUS_C : `BUS_I;
          ilock_nxt = (cls_nxt == `CLS_CP_READ) && use_nxt && (k_nxt == tot_nxt - 7'h02);
        end
        default: dbus_nxt = `BUS_I;
      endcase
      // refill after a program counter write ends with N then S fetches
      if (k_nxt == 7'h00) ibus_nxt = `BUS_S;
      else if (pc_nxt && (cls_nxt == `CLS_DATA_OP || cls_nxt == `CLS_SINGLE_LOAD ||
               cls_nxt == `CLS_BLOCK_LOAD) && k_nxt == tot_nxt - 7'h02) ibus_nxt = `BUS_N;
      else if (pc_nxt && (cls_nxt == `CLS_DATA_OP || cls_nxt == `CLS_SINGLE_LOAD ||
               cls_nxt == `CLS_BLOCK_LOAD) && k_nxt == tot_nxt - 7'h01) ibus_nxt = `BUS_S;
    end
  end

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= 7'h00;
      k_r     <= 7'h00;
      tot_r   <= 7'h00;
      cls_r   <= `CLS_DATA_OP;
      n_r     <= 5'h00;
      b_r     <= 5'h00;
      mask_r  <= 16'h0000;
      pc_r    <= 1'b0;
      use_r   <= 1'b0;
      dep_r   <= 1'b0;
      lng_r   <= 1'b0;
      uns_r   <= 1'b0;
      sel_r   <= 4'h0;
      ready_r <= 1'b0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      dbus_r  <= `BUS_I;
      ibus_r  <= `BUS_I;
      stall_r <= 1'b0;
      ilock_r <= 1'b0;
      xfer_r  <= 1'b0;
      xreg_r  <= 4'h0;
    end else begin
      done_r  <= done_nxt;
      ready_r <= (state_nxt == ST_IDLE);
      // external waits freeze the whole sequence, outputs included
      if (go) begin
        state_r <= state_nxt;
        cnt_r   <= cnt_nxt;
        k_r     <= k_nxt;
        tot_r   <= tot_nxt;
        cls_r   <= cls_nxt;
        n_r     <= n_nxt;
        b_r     <= b_nxt;
        mask_r  <= mask_nxt;
        pc_r    <= pc_nxt;
        use_r   <= use_nxt;
        dep_r   <= dep_nxt;
        lng_r   <= lng_nxt;
        uns_r   <= uns_nxt;
        sel_r   <= sel_nxt;
        busy_r  <= (state_nxt != ST_IDLE);
        dbus_r  <= dbus_nxt;
        ibus_r  <= ibus_nxt;
        stall_r <= (state_nxt != ST_IDLE) && (ibus_nxt == `BUS_I);
        ilock_r <= ilock_nxt;
        xfer_r  <= xfer_nxt;
        xreg_r  <= xreg_nxt;
      end
    end
  end
  assign ready_o        = ready_r;
  assign busy_o         = busy_r;
  assign done_o         = done_r;
  assign cycles_o       = tot_r;
  assign dbus_type_o    = dbus_r;
  assign ibus_type_o    = ibus_r;
  assign ifetch_stall_o = stall_r;
  assign interlock_o    = ilock_r;
  assign xfer_valid_o   = xfer_r;
  assign xfer_reg_o     = xreg_r;
  assign mul_reg_sel_o  = sel_r;

endmodule

// File: verification/instruction_timing_interlock_sva.sv
// timing and interlock checks on the controller ports
// assumes binding to the design top, one clock domain
`timescale 1ns/1ns
module instruction_timing_interlock_sva (
  input wire        sys_clk_i,
  input wire        sys_rst_i,
  input wire        issue_i,
  input wire [3:0]  class_i,
  input wire        long_mul_i,
  input wire        compressed_i,
  input wire [31:0] instr_i,
  input wire        ext_wait_i,
  input wire        ready_o,
  input wire        busy_o,
  input wire        done_o,
  input wire [6:0]  cycles_o,
  input wire [1:0]  ibus_type_o,
  input wire        ifetch_stall_o,
  input wire        interlock_o,
  input wire        xfer_valid_o,
  input wire [3:0]  xfer_reg_o,
  input wire [3:0]  mul_reg_sel_o
);
  reg  [6:0] adv_r;
  reg  [6:0] adv_nxt;
  wire [3:0] sel_exp = compressed_i ? {1'b0, instr_i[2:0]} : instr_i[11:8];
  // stalled cycles repeat, so only advancing busy cycles are counted
  always @* begin
    adv_nxt = adv_r;
    if (done_o)
      adv_nxt = 7'h00;
    else if (busy_o && !ext_wait_i)
      adv_nxt = adv_r + 7'h01;
  end
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      adv_r <= 7'h00;
    else
      adv_r <= adv_nxt;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_busy_follows_issue: assert property (issue_i && ready_o |=> busy_o && !ready_o)
    else $error("busy did not follow issue");
  chk_count_matches: assert property (done_o |-> adv_r == cycles_o)
    else $error("busy cycles differ from reported count");
  chk_done_ends_op: assert property (done_o |-> ready_o && !busy_o ##1 !done_o)
    else $error("done pulse malformed");
  chk_idle_fetch_stall: assert property (busy_o && ibus_type_o == 2'h0 |-> ifetch_stall_o)
    else $error("fetch not halted in idle bus cycle");
  chk_interlock_halts: assert property (interlock_o |-> ifetch_stall_o && busy_o)
    else $error("interlock without fetch halt");
  chk_xfer_ascends: assert property (xfer_valid_o && busy_o && $past(xfer_valid_o) && $past(busy_o)
    && !$past(ext_wait_i) |-> xfer_reg_o > $past(xfer_reg_o))
    else $error("block transfer order not ascending");
  chk_mul_operand_sel: assert property (issue_i && ready_o && class_i == 4'hb |=> mul_reg_sel_o == $past(sel_exp))
    else $error("wrong multiply operand register");
  chk_mul_short_span: assert property (issue_i && ready_o && class_i == 4'hb && !long_mul_i
    |=> ext_wait_i or ##1 (cycles_o >= 7'h03 && cycles_o <= 7'h06))
    else $error("short multiply count out of range");
  chk_busy_bounded: assert property ($rose(busy_o) |-> ##[1:200] done_o)
    else $error("operation never completed");
  cover property (interlock_o);
  cover property (xfer_valid_o ##1 xfer_valid_o);
  cover property (done_o && issue_i);
endmodule

// File: verification/instruction_timing_interlock_tb.sv
// self-checking bench for the timing and interlock controller
// assumes reg_file_model as far side and the bound checker
`timescale 1ns/1ns
`include "instr_timing_regs.vh"
module instruction_timing_interlock_tb;
  reg         clk, rst, iss, pcd, rsh, nxt, nar, flg, lng, uns, cmp, dl, slow;
  reg  [3:0]  cls;
  reg  [31:0] ins;
  reg  [15:0] rl;
  reg  [4:0]  cb, cw;
  wire [31:0] opv;
  wire        wt, rdy, bsy, dn, xv, il;
  wire [6:0]  cyc;
  wire [3:0]  xr, sel;
  wire [1:0]  db;
  integer     miscompares, tests_run, nb, ni, nx;
  reg  [3:0]  xq [0:15];
  reg  [1:0]  dq [0:15];
  instruction_timing_interlock instruction_timing_interlock_i (.sys_clk_i(clk), .sys_rst_i(rst),
    .issue_i(iss), .class_i(cls), .pc_dest_i(pcd), .reg_shift_i(rsh), .next_uses_i(nxt),
    .narrow_i(nar), .flags_only_i(flg), .long_mul_i(lng), .unsigned_mul_i(uns), .compressed_i(cmp),
    .instr_i(ins), .reg_list_i(rl), .coproc_busy_i(cb), .coproc_words_i(cw), .dep_last_i(dl),
    .mul_operand_i(opv), .ext_wait_i(wt), .ready_o(rdy), .busy_o(bsy), .done_o(dn), .cycles_o(cyc),
    .dbus_type_o(db), .ibus_type_o(), .ifetch_stall_o(), .interlock_o(il), .xfer_valid_o(xv),
    .xfer_reg_o(xr), .mul_reg_sel_o(sel));
  reg_file_model reg_file_model_i (.clk_i(clk), .rst_i(rst), .slow_i(slow), .busy_i(bsy),
    .sel_i(sel), .operand_o(opv), .wait_o(wt));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("mismatch %s expected %0h seen %0h", nm, e, s);
      end
    end
  endtask
  task clr;
    begin
      {pcd, rsh, nxt, nar, flg, lng, uns, cmp, dl, slow} = 10'h000;
      ins = 32'h00000000;
      rl = 16'h0000;
      cb = 5'h00;
      cw = 5'h01;
    end
  endtask
  // issued at the falling edge of the done cycle, so runs are back to back
  task go(input [3:0] c, input [6:0] e);
    integer k;
    reg     pw;
    begin
      chk("ready", 1, rdy);
      cls = c;
      iss = 1'b1;
      @(negedge clk);
      iss = 1'b0;
      nb = 0;
      ni = 0;
      nx = 0;
      pw = 1'b0;
      for (k = 0; k < 200 && dn !== 1'b1; k = k + 1) begin
        nb = nb + bsy;
        // a held cycle repeats the one before, so interlocks and transfers are taken from fresh cycles only
        if (!pw) begin
          ni = ni + il;
          if (xv === 1'b1) begin
            xq[nx] = xr;
            dq[nx] = db;
            nx = nx + 1;
          end
        end
        pw = wt;
        @(negedge clk);
      end
      chk("done", 1, dn);
      chk("cycles", e, cyc);
      if (!slow)
        chk("busy", e, nb);
    end
  endtask
  task t_data;
    begin
      clr;
      go(`CLS_DATA_OP, 7'h01);
      rsh = 1'b1;
      go(`CLS_DATA_OP, 7'h02);
      pcd = 1'b1;
      go(`CLS_DATA_OP, 7'h04);
      rsh = 1'b0;
      go(`CLS_DATA_OP, 7'h03);
      flg = 1'b1;
      go(`CLS_STATUS_WRITE, 7'h01);
      flg = 1'b0;
      go(`CLS_STATUS_WRITE, 7'h03);
      $display("t_data done");
    end
  endtask
  task t_load;
    begin
      clr;
      go(`CLS_SINGLE_LOAD, 7'h01);
      go(`CLS_SINGLE_STORE, 7'h01);
      nxt = 1'b1;
      go(`CLS_SINGLE_LOAD, 7'h02);
      chk("interlock", 1, ni);
      nar = 1'b1;
      go(`CLS_SINGLE_LOAD, 7'h03);
      chk("interlock", 2, ni);
      go(`CLS_SWAP, 7'h03);
      nxt = 1'b0;
      go(`CLS_SWAP, 7'h03);
      nar = 1'b0;
      go(`CLS_SWAP, 7'h02);
      pcd = 1'b1;
      go(`CLS_SINGLE_LOAD, 7'h05);
      $display("t_load done");
    end
  endtask
  task t_block;
    begin
      clr;
      rl = 16'h0020;
      go(`CLS_BLOCK_LOAD, 7'h02);
      rl = 16'h000e;
      go(`CLS_BLOCK_LOAD, 7'h03);
      chk("order", 12'h123, {xq[0], xq[1], xq[2]});
      nxt = 1'b1;
      go(`CLS_BLOCK_LOAD, 7'h03);
      chk("interlock", 1, ni);
      nxt = 1'b0;
      dl = 1'b1;
      go(`CLS_BLOCK_LOAD, 7'h04);
      chk("interlock", 1, ni);
      dl = 1'b0;
      pcd = 1'b1;
      rl = 16'h8001;
      go(`CLS_BLOCK_LOAD, 7'h06);
      rl = 16'h0010;
      go(`CLS_BLOCK_STORE, 7'h02);
      chk("dbus", 2'h1, dq[0]);
      rl = 16'h020a;
      go(`CLS_BLOCK_STORE, 7'h03);
      chk("order", 12'h139, {xq[0], xq[1], xq[2]});
      chk("dbus", 6'h1a, {dq[0], dq[1], dq[2]});
      $display("t_block done");
    end
  endtask
  task t_cop;
    begin
      clr;
      cb = 5'h03;
      cw = 5'h02;
      go(`CLS_CP_DATA, 7'h04);
      go(`CLS_CP_MEM, 7'h05);
      go(`CLS_CP_WRITE, 7'h04);
      go(`CLS_CP_READ, 7'h04);
      nxt = 1'b1;
      go(`CLS_CP_READ, 7'h05);
      cb = 5'h00;
      go(`CLS_CP_DATA, 7'h01);
      $display("t_cop done");
    end
  endtask
  task mc(input [31:0] v, input l, input u, input c, input [6:0] e);
    begin
      reg_file_model_i.rf[c ? 2 : 5] = v;
      lng = l;
      uns = u;
      cmp = c;
      go(`CLS_MULTIPLY, e);
    end
  endtask
  task t_mul;
    begin
      clr;
      ins = 32'h00000502;
      mc(32'h000000ff, 0, 0, 0, 7'h03);
      mc(32'hffff8000, 0, 0, 0, 7'h04);
      mc(32'h00ff0000, 0, 0, 0, 7'h05);
      mc(32'h12345678, 0, 0, 0, 7'h06);
      mc(32'hffffff80, 1, 0, 0, 7'h04);
      mc(32'hffffff80, 1, 1, 0, 7'h07);
      mc(32'h00000012, 1, 1, 0, 7'h04);
      mc(32'h00001234, 0, 0, 1, 7'h04);
      $display("t_mul done");
    end
  endtask
  task t_wait;
    begin
      clr;
      slow = 1'b1;
      rl = 16'h000e;
      go(`CLS_BLOCK_LOAD, 7'h03);
      chk("stretch", 1, nb > 3);
      chk("order", 12'h123, {xq[0], xq[1], xq[2]});
      $display("t_wait done");
    end
  endtask
  task summarize;
    begin
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    miscompares = 0;
    tests_run = 0;
    rst = 1'b1;
    iss = 1'b0;
    cls = 4'h0;
    clr;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_data;
    t_load;
    t_block;
    t_cop;
    t_mul;
    t_wait;
    summarize;
  end
  initial begin
    #400000;
    miscompares = miscompares + 1;
    summarize;
  end
endmodule
bind instruction_timing_interlock instruction_timing_interlock_sva instruction_timing_interlock_sva_i (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .issue_i(issue_i), .class_i(class_i),
  .long_mul_i(long_mul_i), .compressed_i(compressed_i), .instr_i(instr_i), .ext_wait_i(ext_wait_i),
  .ready_o(ready_o), .busy_o(busy_o), .done_o(done_o), .cycles_o(cycles_o), .ibus_type_o(ibus_type_o),
  .ifetch_stall_o(ifetch_stall_o), .interlock_o(interlock_o), .xfer_valid_o(xfer_valid_o),
  .xfer_reg_o(xfer_reg_o), .mul_reg_sel_o(mul_reg_sel_o));

// File: verification/reg_file_model.sv
// register file and memory side stand-in for the controller
// assumes the bench loads rf directly and commands slow mode
`timescale 1ns/1ns
module reg_file_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        slow_i,
  input  wire        busy_i,
  input  wire [3:0]  sel_i,
  output reg  [31:0] operand_o,
  output reg         wait_o
);
  reg [31:0] rf [0:15];
  always @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      operand_o <= 32'h00000000;
    end else begin
      // not read outside an operation, so show nothing stale
      operand_o <= busy_i ? rf[sel_i] : ~operand_o;
    end
  end
  // wait moves just after the rising edge, so it stands settled at the falling edge
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      wait_o <= 1'b0;
    else
      wait_o <= slow_i && busy_i && !wait_o;
  end
endmodule
